// ---- hw/sbir_edge_sync.sv ----
`timescale 1ns/1ns
module sbir_edge_sync
(
    // clock and reset
    input  wire logic                        mclk,
    input  wire logic                        sys_rst,
    // asynchronous levels in, rising-edge pulses out
    input  wire logic [sbir_pkg::DATA_W-1:0] levelIn,
    output logic      [sbir_pkg::DATA_W-1:0] risePulse
);

    import sbir_pkg::*;

    logic [DATA_W-1:0] meta_r;
    logic [DATA_W-1:0] sync_r;
    logic [DATA_W-1:0] prev_r;

    // ------------------------------------------------------------
    // per-bit two-flop synchroniser and edge detect
    // ------------------------------------------------------------
    for (genvar i = 0; i < DATA_W; i++) begin : g_bit
        always_ff @(posedge mclk or posedge sys_rst) begin
            if (sys_rst) begin
                meta_r[i] <= 1'b0;
                sync_r[i] <= 1'b0;
                prev_r[i] <= 1'b0;
            end else begin
                meta_r[i] <= levelIn[i];
                sync_r[i] <= meta_r[i];
                prev_r[i] <= sync_r[i];
            end
        end
        assign risePulse[i] = sync_r[i] & ~prev_r[i];
    end

endmodule

// ---- hw/sbir_pkg.sv ----
package sbir_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int          ADDR_W          = 18;
    localparam int          DATA_W          = 8;
    localparam logic [17:0] CAUSE_OFFSET    = 18'h00010;
    localparam logic [17:0] USER_EN_OFFSET  = 18'h00012;
    localparam logic [17:0] HOST_EN_OFFSET  = 18'h00013;
    localparam logic [7:0]  CAUSE_RESET     = 8'h00;
    localparam logic [7:0]  USER_EN_RESET   = 8'h00;
    localparam logic [7:0]  HOST_EN_RESET   = 8'h00;
    localparam logic [7:0]  USED_BITS_MASK  = 8'hfe;

    // ------------------------------------------------------------
    // cause bit positions
    // ------------------------------------------------------------
    localparam int BIT_PCS       = 1;
    localparam int BIT_HOST      = 2;
    localparam int BIT_CFG_ERR   = 3;
    localparam int BIT_CFG_DATA  = 4;
    localparam int BIT_USER_MST  = 5;
    localparam int BIT_USER_SLV  = 6;
    localparam int BIT_USER_IN   = 7;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic {
        SBIR_HOST_PORT,
        SBIR_USER_MASTER
    } sbir_master_e;

    typedef struct packed {
        logic              valid;
        logic              write;
        sbir_master_e      master;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } sbir_req_s;

    typedef struct packed {
        logic              valid;
        logic [DATA_W-1:0] rdata;
    } sbir_rsp_s;

endpackage

// ---- hw/sbir_router.sv ----
`timescale 1ns/1ns
module sbir_router
(
    // clock and resets
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    input  wire logic       busResetLow_n,
    // interrupt sources
    input  wire logic       pcsIrq,
    input  wire logic       hostPortIrq,
    input  wire logic       hostParityErr,
    input  wire logic       hostParityCheckEn,
    input  wire logic       cfgErrIrq,
    input  wire logic       cfgDataIrq,
    input  wire logic       userMasterIrq,
    input  wire logic       userSlaveIrqPulse,
    input  wire logic       userIrqIn,
    // register access from bus masters
    input  sbir_pkg::sbir_req_s req,
    output sbir_pkg::sbir_rsp_s rsp,
    // interrupt and clock outputs
    output logic            userIrqOut,
    output logic            hostIrqOut_n,
    output logic            syncClk
);

    import sbir_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic              rstMeta_r;
    logic              rstSync_r;
    logic              busRst;
    logic [DATA_W-1:0] srcLevel;
    logic [DATA_W-1:0] srcRise;
    logic [DATA_W-1:0] cause_r;
    logic [DATA_W-1:0] cause_nxt;
    logic [DATA_W-1:0] userEn_r;
    logic [DATA_W-1:0] hostEn_r;
    logic [DATA_W-1:0] causeClr;
    logic              wrCause;
    logic              wrUserEn;
    logic              wrHostEn;
    logic              userIrq_r;
    logic              hostIrq_n_r;
    logic              syncClk_r;
    sbir_rsp_s         rsp_r;
    sbir_rsp_s         rsp_nxt;
    logic [DATA_W-1:0] userEn_nxt;
    logic [DATA_W-1:0] hostEn_nxt;
    logic [DATA_W-1:0] userPend;
    logic [DATA_W-1:0] hostPend;
    logic              userIrq_nxt;
    logic              hostIrq_n_nxt;
    logic              syncClk_nxt;

    // ------------------------------------------------------------
    // bus reset synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rstMeta_r <= 1'b1;
            rstSync_r <= 1'b1;
        end else begin
            rstMeta_r <= ~busResetLow_n;
            rstSync_r <= rstMeta_r;
        end
    end
    assign busRst = rstSync_r;

    // ------------------------------------------------------------
    // source map and edge capture
    // ------------------------------------------------------------
    always_comb begin
        srcLevel               = '0;
        srcLevel[BIT_PCS]      = pcsIrq;
        srcLevel[BIT_HOST]     = hostPortIrq | (hostParityErr & hostParityCheckEn);
        srcLevel[BIT_CFG_ERR]  = cfgErrIrq;
        srcLevel[BIT_CFG_DATA] = cfgDataIrq;
        srcLevel[BIT_USER_MST] = userMasterIrq;
        srcLevel[BIT_USER_SLV] = userSlaveIrqPulse;
        srcLevel[BIT_USER_IN]  = userIrqIn;
    end

    sbir_edge_sync sbir_edge_sync_i (
        .mclk      (mclk),
        .sys_rst   (sys_rst),
        .levelIn   (srcLevel),
        .risePulse (srcRise)
    );

    // ------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------
    assign wrCause  = req.valid & req.write & (req.addr == CAUSE_OFFSET);
    assign wrUserEn = req.valid & req.write & (req.addr == USER_EN_OFFSET)
                      & (req.master == SBIR_USER_MASTER);
    assign wrHostEn = req.valid & req.write & (req.addr == HOST_EN_OFFSET)
                      & (req.master == SBIR_HOST_PORT);
    assign causeClr = wrCause ? req.wdata : '0;

    // ------------------------------------------------------------
    // cause register: set wins over clear, source not touched
    // ------------------------------------------------------------
    assign cause_nxt = ((cause_r & ~causeClr) | srcRise) & USED_BITS_MASK;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            cause_r <= CAUSE_RESET;
        end else if (busRst) begin
            cause_r <= CAUSE_RESET;
        end else begin
            cause_r <= cause_nxt;
        end
    end

    // ------------------------------------------------------------
    // enable next values, writes gated by master
    // ------------------------------------------------------------
    always_comb begin
        userEn_nxt = userEn_r;
        if (wrUserEn) begin
            userEn_nxt = req.wdata & USED_BITS_MASK;
        end
    end

    always_comb begin
        hostEn_nxt = hostEn_r;
        if (wrHostEn) begin
            hostEn_nxt = req.wdata & USED_BITS_MASK;
        end
    end

    // ------------------------------------------------------------
    // enable registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            userEn_r <= USER_EN_RESET;
        end else if (busRst) begin
            userEn_r <= USER_EN_RESET;
        end else begin
            userEn_r <= userEn_nxt;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            hostEn_r <= HOST_EN_RESET;
        end else if (busRst) begin
            hostEn_r <= HOST_EN_RESET;
        end else begin
            hostEn_r <= hostEn_nxt;
        end
    end

    // ------------------------------------------------------------
    // pending causes per output
    // ------------------------------------------------------------
    assign userPend      = cause_r & userEn_r;
    assign hostPend      = cause_r & hostEn_r;
    assign userIrq_nxt   = |userPend;
    assign hostIrq_n_nxt = ~|hostPend;

    // ------------------------------------------------------------
    // interrupt outputs
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            userIrq_r   <= 1'b0;
            hostIrq_n_r <= 1'b1;
        end else if (busRst) begin
            userIrq_r   <= 1'b0;
            hostIrq_n_r <= 1'b1;
        end else begin
            userIrq_r   <= userIrq_nxt;
            hostIrq_n_r <= hostIrq_n_nxt;
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    always_comb begin
        rsp_nxt       = '0;
        rsp_nxt.valid = req.valid & ~req.write;
        if (req.valid && !req.write) begin
            case (req.addr)
                CAUSE_OFFSET:   rsp_nxt.rdata = cause_r;
                USER_EN_OFFSET: rsp_nxt.rdata = userEn_r;
                HOST_EN_OFFSET: rsp_nxt.rdata = hostEn_r;
                default:        rsp_nxt.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rsp_r <= '0;
        end else if (busRst) begin
            rsp_r <= '0;
        end else begin
            rsp_r <= rsp_nxt;
        end
    end

    // ------------------------------------------------------------
    // synchronous clock output
    // ------------------------------------------------------------
    assign syncClk_nxt = ~syncClk_r;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            syncClk_r <= 1'b0;
        end else begin
            syncClk_r <= syncClk_nxt;
        end
    end

    assign rsp          = rsp_r;
    assign userIrqOut   = userIrq_r;
    assign hostIrqOut_n = hostIrq_n_r;
    assign syncClk      = syncClk_r;

endmodule

// ---- tb/sbir_router_asserts.sv ----
`timescale 1ns/1ns
module sbir_router_asserts
    import sbir_pkg::*;
(
    // clock, resets and sources
    input wire logic           mclk,
    input wire logic           sys_rst,
    input wire logic           busResetLow_n,
    input wire logic           pcsIrq,
    input wire logic           hostPortIrq,
    input wire logic           hostParityErr,
    input wire logic           hostParityCheckEn,
    input wire logic           cfgErrIrq,
    input wire logic           cfgDataIrq,
    input wire logic           userMasterIrq,
    input wire logic           userSlaveIrqPulse,
    input wire logic           userIrqIn,
    // bus and outputs
    input sbir_pkg::sbir_req_s req,
    input sbir_pkg::sbir_rsp_s rsp,
    input wire logic           userIrqOut,
    input wire logic           hostIrqOut_n,
    input wire logic           syncClk
);
    // ------------------------------------------------------------
    // event history and checks
    // ------------------------------------------------------------
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    logic [7:0] srcs;
    logic [7:0] srcsPrev_r;
    logic [5:0] evtHist_r;
    logic       rdReq;
    assign srcs  = {userIrqIn, userSlaveIrqPulse, userMasterIrq, cfgDataIrq,
                    cfgErrIrq, hostPortIrq, pcsIrq, hostParityErr};
    assign rdReq = req.valid && !req.write;
    always_ff @(posedge mclk) begin
        srcsPrev_r <= srcs;
    end
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            evtHist_r <= 6'h00;
        end else begin
            evtHist_r <= {evtHist_r[4:0], (|(srcs & ~srcsPrev_r)) | (req.valid & req.write)};
        end
    end
    chk_read_answer: assert property (rdReq |=> rsp.valid)
        else $error("read without answer");
    chk_no_extra: assert property (!rdReq |=> !rsp.valid)
        else $error("answer without read");
    chk_bit0_zero: assert property (rsp.valid |-> !rsp.rdata[0])
        else $error("bit 0 read as one");
    chk_unmapped_zero: assert property (rdReq && req.addr != CAUSE_OFFSET
        && req.addr != USER_EN_OFFSET && req.addr != HOST_EN_OFFSET |=> rsp.rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_sync_clk: assert property (1'b1 |=> syncClk != $past(syncClk))
        else $error("sync clock not toggling");
    chk_clear_idle: assert property (req.valid && req.write
        && req.addr == CAUSE_OFFSET && req.wdata == 8'hfe && srcs == 8'h00
        && $past(srcs) == 8'h00 && $past(srcs, 2) == 8'h00 && $past(srcs, 3) == 8'h00
        |-> ##2 !userIrqOut && hostIrqOut_n)
        else $error("outputs active after clear");
    chk_bus_reset_idle: assert property (!busResetLow_n [*3]
        |-> ##2 !userIrqOut && hostIrqOut_n)
        else $error("outputs active in bus reset");
    chk_rise_has_cause: assert property ($rose(userIrqOut) || $fell(hostIrqOut_n)
        |-> evtHist_r != 6'h00)
        else $error("interrupt without cause");
endmodule
bind sbir_router sbir_router_asserts sbir_router_asserts_i (.mclk, .sys_rst, .busResetLow_n,
    .pcsIrq, .hostPortIrq, .hostParityErr, .hostParityCheckEn, .cfgErrIrq, .cfgDataIrq,
    .userMasterIrq, .userSlaveIrqPulse, .userIrqIn, .req, .rsp, .userIrqOut, .hostIrqOut_n,
    .syncClk);

// ---- tb/sbir_router_test.sv ----
`timescale 1ns/1ns
module sbir_router_test;
    import sbir_pkg::*;
    // ------------------------------------------------------------
    // bench
    // ------------------------------------------------------------
    logic       mclk, sys_rst, busResetLow_n, hostParityErr, hostParityCheckEn;
    logic       userIrqOut, hostIrqOut_n, syncClk;
    logic       syncPrev;
    logic [7:0] lvl, pls, src;
    sbir_req_s  req;
    sbir_rsp_s  rsp;
    int         errors, checked;
    sbir_src_model sbir_src_model_i (.mclk, .lvl, .pls, .src);
    sbir_router sbir_router_i (.mclk, .sys_rst, .busResetLow_n, .pcsIrq(src[1]),
        .hostPortIrq(src[2]), .hostParityErr, .hostParityCheckEn, .cfgErrIrq(src[3]),
        .cfgDataIrq(src[4]), .userMasterIrq(src[5]), .userSlaveIrqPulse(src[6]),
        .userIrqIn(src[7]), .req, .rsp, .userIrqOut, .hostIrqOut_n, .syncClk);
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic acc(input sbir_master_e m, input logic w, input logic [17:0] a,
                       input logic [7:0] d);
        @(negedge mclk);
        req = '{1'b1, w, m, a, d};
        @(negedge mclk);
        req.valid = 1'b0;
    endtask
    task automatic rd(input logic [17:0] a, input logic [7:0] exp);
        acc(SBIR_HOST_PORT, 1'b0, a, 8'h00);
        chk("answer", 8'h01, {7'h00, rsp.valid});
        chk("read data", exp, rsp.rdata);
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic fire(input int b);
        @(negedge mclk);
        pls[b] = 1'b1;
        @(negedge mclk);
        pls[b] = 1'b0;
        idle(5);
    endtask
    task automatic irqs(input logic u, input logic h);
        chk("user irq", {7'h00, u}, {7'h00, userIrqOut});
        chk("host irq", {7'h00, h}, {7'h00, hostIrqOut_n});
    endtask
    task automatic test_done;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        #400000;
        errors++;
        test_done;
    end
    initial begin
        sys_rst = 1'b1;
        busResetLow_n = 1'b1;
        hostParityErr = 1'b0;
        hostParityCheckEn = 1'b0;
        {lvl, pls, req, errors, checked} = '0;
        repeat (5) @(posedge mclk);
        @(negedge mclk);
        sys_rst = 1'b0;
        idle(3);
        rd(CAUSE_OFFSET, CAUSE_RESET);
        rd(USER_EN_OFFSET, USER_EN_RESET);
        rd(HOST_EN_OFFSET, HOST_EN_RESET);
        acc(SBIR_HOST_PORT, 1'b1, 18'h00011, 8'hff);
        rd(18'h00011, 8'h00);
        irqs(1'b0, 1'b1);
        syncPrev = syncClk;
        idle(1);
        chk("sync clock", {7'h00, ~syncPrev}, {7'h00, syncClk});
        acc(SBIR_HOST_PORT, 1'b1, USER_EN_OFFSET, 8'hff);
        acc(SBIR_USER_MASTER, 1'b1, HOST_EN_OFFSET, 8'hff);
        rd(USER_EN_OFFSET, 8'h00);
        rd(HOST_EN_OFFSET, 8'h00);
        acc(SBIR_USER_MASTER, 1'b1, USER_EN_OFFSET, 8'hff);
        acc(SBIR_HOST_PORT, 1'b1, HOST_EN_OFFSET, 8'hff);
        rd(USER_EN_OFFSET, USED_BITS_MASK);
        rd(HOST_EN_OFFSET, USED_BITS_MASK);
        for (int b = 1; b < 8; b++) begin
            fire(b);
            rd(CAUSE_OFFSET, 8'h01 << b);
            irqs(1'b1, 1'b0);
            acc(sbir_master_e'(b % 2), 1'b1, CAUSE_OFFSET, 8'hfe);
            idle(2);
            rd(CAUSE_OFFSET, 8'h00);
            irqs(1'b0, 1'b1);
        end
        acc(SBIR_USER_MASTER, 1'b1, USER_EN_OFFSET, 8'h20);
        acc(SBIR_HOST_PORT, 1'b1, HOST_EN_OFFSET, 8'h40);
        fire(5);
        irqs(1'b1, 1'b1);
        fire(6);
        irqs(1'b1, 1'b0);
        rd(CAUSE_OFFSET, 8'h60);
        acc(SBIR_USER_MASTER, 1'b1, CAUSE_OFFSET, 8'h20);
        idle(2);
        irqs(1'b0, 1'b0);
        for (int e = 1; e >= 0; e--) begin
            acc(SBIR_HOST_PORT, 1'b1, CAUSE_OFFSET, 8'hfe);
            hostParityCheckEn = e[0];
            hostParityErr = 1'b1;
            idle(2);
            hostParityErr = 1'b0;
            idle(5);
            rd(CAUSE_OFFSET, {5'h00, e[0], 2'h0});
        end
        lvl[7] = 1'b1;
        idle(5);
        acc(SBIR_HOST_PORT, 1'b1, CAUSE_OFFSET, 8'hfe);
        idle(5);
        rd(CAUSE_OFFSET, 8'h00);
        chk("source held", 8'h80, src & 8'h80);
        lvl[7] = 1'b0;
        acc(SBIR_HOST_PORT, 1'b1, HOST_EN_OFFSET, 8'hff);
        fire(1);
        irqs(1'b0, 1'b0);
        busResetLow_n = 1'b0;
        idle(4);
        busResetLow_n = 1'b1;
        idle(3);
        rd(HOST_EN_OFFSET, 8'h00);
        rd(CAUSE_OFFSET, 8'h00);
        irqs(1'b0, 1'b1);
        test_done;
    end
endmodule

// ---- tb/sbir_src_model.sv ----
`timescale 1ns/1ns
module sbir_src_model (
    // clock and requests
    input wire logic       mclk,
    input wire logic [7:0] lvl,
    input wire logic [7:0] pls,
    // active high source levels
    output logic     [7:0] src
);
    // ------------------------------------------------------------
    // pulses stretched past one interface clock period
    // ------------------------------------------------------------
    logic [7:0] p1_r;
    logic [7:0] p2_r;
    always_ff @(posedge mclk) begin
        p1_r <= pls;
        p2_r <= p1_r;
    end
    assign src = lvl | pls | p1_r | p2_r;
endmodule
